// file: gsc_core.sv
// Purpose: common commands, status byte, error queue, test function status
// Assumes: one command at a time from the parser, inputs synchronous
// Notes: answers are posted on resp_* with a one-cycle resp_valid pulse
`timescale 1ns/1ps
`default_nettype none
`include "gsc_cfg.svh"
module gsc_core #(
   parameter int SLOTS = `GSC_SLOTS,
   parameter int DEPTH = `GSC_ERRQ_DEPTH
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cmd_valid,
   input wire gsc_pkg::gsc_cmd_t cmd,
   input wire logic [8:0] cmd_arg,
   input wire logic busy,
   input wire logic [SLOTS*8-1:0] slot_ids,
   input wire logic bad_mnemonic,
   input wire logic get_mid_record,
   input wire logic param_range_err,
   input wire logic idle_cmd,
   input wire logic tester_idle,
   input wire logic cal_start,
   input wire logic cal_op,
   input wire logic cal_running,
   input wire logic [7:0] status_cond,
   input wire logic tf_done,
   input wire gsc_pkg::gsc_tf_t tf_result,
   input wire logic spoll,
   output logic [7:0] spoll_byte,
   output logic srq,
   output logic resp_valid,
   output logic [15:0] resp_value,
   output logic resp_is_warn,
   output logic [SLOTS*8-1:0] opt_fields,
   output logic [10:0] tf_status,
   output logic sys_reset
);
   import gsc_pkg::*;
   localparam int AW = $clog2(DEPTH);
   // ---------------------------------------------
   // internal signals and helper functions
   // ---------------------------------------------
   logic [7:0] esr, next_esr;
   logic [7:0] ese, next_ese;
   logic [7:0] sre, next_sre;
   logic rqs, next_rqs;
   logic mss_q, next_mss_q;
   logic opc_pend, next_opc_pend;
   logic opcq_pend, next_opcq_pend;
   logic [9:0] q_mem [DEPTH];
   logic [AW:0] wp, next_wp, rp, next_rp;
   logic [9:0] log_code;
   logic log_en;
   logic next_rv;
   logic [15:0] next_rvalue;
   logic next_warn;
   logic [10:0] next_tf;
   logic mss;
   logic [7:0] stb;
   logic qempty;
   logic qfull;
   function automatic logic is_warn(input logic [9:0] code);
      is_warn = code >= `GSC_WARN_FIRST;
   endfunction
   // values above 256 are refused; 256 itself is accepted and truncated to zero
   function automatic logic sre_ok(input logic [8:0] v);
      sre_ok = v <= `GSC_SRE_MAX;
   endfunction
   function automatic logic rst_cmd(input logic v, input gsc_cmd_t c);
      rst_cmd = v && c == GSC_CMD_RST;
   endfunction
   // ---------------------------------------------
   // error queue flags
   // ---------------------------------------------
   // full drops new codes so the oldest ones survive
   assign qempty = (wp == rp);
   assign qfull = (wp[AW-1:0] == rp[AW-1:0]) && (wp[AW] != rp[AW]);
   // ---------------------------------------------
   // status byte and summary
   // ---------------------------------------------
   // bits 5 and 6 of status_cond are replaced by the event summary and request bits
   assign mss = |(status_cond & sre & 8'h9F) || (|(esr & ese) && sre[`GSC_STB_ESB]);
   always_comb
   begin
      stb = status_cond;
      stb[`GSC_STB_ESB] = |(esr & ese);
      stb[`GSC_STB_RQS] = rqs;
   end
   // ---------------------------------------------
   // error logging
   // ---------------------------------------------
   always_comb
   begin
      log_en = 1'b1;
      log_code = `GSC_ERR_NONE;
      if (bad_mnemonic)
         log_code = `GSC_ERR_MNEMONIC;
      else if (get_mid_record)
         log_code = `GSC_ERR_GET_MID;
      else if (param_range_err || (cmd_valid && cmd == GSC_CMD_SRE && !sre_ok(cmd_arg)))
         log_code = `GSC_ERR_RANGE;
      else if (idle_cmd && !tester_idle)
         log_code = `GSC_ERR_NOT_IDLE;
      else if (cal_start && cal_running)
         log_code = `GSC_ERR_CAL_BUSY;
      else if (cal_op && !cal_running)
         log_code = `GSC_ERR_CAL_IDLE;
      else
         log_en = 1'b0;
   end
   // ---------------------------------------------
   // command decode and state update
   // ---------------------------------------------
   always_comb
   begin
      next_esr = esr;
      next_ese = ese;
      next_sre = sre;
      next_opc_pend = opc_pend;
      next_opcq_pend = opcq_pend;
      next_mss_q = mss;
      next_rqs = rqs;
      next_wp = wp;
      next_rp = rp;
      next_rv = 1'b0;
      next_rvalue = resp_value;
      next_warn = 1'b0;
      next_tf = tf_status;
      // poll clears request bit only; other bits untouched
      if (spoll)
         next_rqs = 1'b0;
      // rising summary means a new enabled reason; set wins over poll clear
      if (mss && !mss_q)
         next_rqs = 1'b1;
      if (!mss)
         next_rqs = 1'b0;
      if (opc_pend && !busy)
         next_opc_pend = 1'b0;
      if (opcq_pend && !busy)
      begin
         next_rv = 1'b1;
         next_rvalue = 16'h0001;
         next_opcq_pend = 1'b0;
      end
      if (log_en && !qfull)
         next_wp = wp + 1'b1;
      if (tf_done)
      begin
         unique case (tf_result)
            GSC_TF_FAILED: next_tf = `GSC_TF_FAIL;
            GSC_TF_PASSED: next_tf = `GSC_TF_PASS;
            GSC_TF_WARNED: next_tf = `GSC_TF_WARN;
            GSC_TF_BROKEN: next_tf = `GSC_TF_BREAK;
         endcase
      end
      if (cmd_valid)
      begin
         unique case (cmd)
            GSC_CMD_OPC: next_opc_pend = 1'b1;
            GSC_CMD_OPCQ: next_opcq_pend = 1'b1;
            GSC_CMD_OPTQ:
            begin
               next_rv = 1'b1;
               next_rvalue = 16'(SLOTS);
            end
            GSC_CMD_SRE:
               if (sre_ok(cmd_arg))
                  next_sre = cmd_arg[7:0];
            GSC_CMD_ESE: next_ese = cmd_arg[7:0];
            GSC_CMD_STBQ:
            begin
               next_rv = 1'b1;
               next_rvalue = {8'h00, stb[7], mss, stb[5:0]};
            end
            GSC_CMD_ESRQ:
            begin
               next_rv = 1'b1;
               next_rvalue = {8'h00, esr};
               next_esr = 8'h00;
            end
            GSC_CMD_CLS:
            begin
               next_esr = 8'h00;
               // a code logged in this same cycle is dropped with the rest
               next_wp = rp;
            end
            GSC_CMD_ERRQ:
            begin
               next_rv = 1'b1;
               next_rvalue = qempty ? 16'(`GSC_ERR_NONE) : 16'(q_mem[rp[AW-1:0]]);
               next_warn = !qempty && is_warn(q_mem[rp[AW-1:0]]);
               if (!qempty)
                  next_rp = rp + 1'b1;
            end
            GSC_CMD_WAI: ; // no overlapping commands exist
            default: ;
         endcase
      end
      // completion event set after the case so a read or clear cannot swallow it
      if (opc_pend && !busy)
         next_esr[`GSC_ESR_OPC] = 1'b1;
      if (rst_cmd(cmd_valid, cmd))
      begin
         next_esr = 8'h00;
         next_ese = 8'h00;
         next_sre = 8'h00;
         next_rqs = 1'b0;
         next_opc_pend = 1'b0;
         next_opcq_pend = 1'b0;
         // pointers reset too so stale codes never reach a query
         next_wp = '0;
         next_rp = '0;
         next_tf = `GSC_TF_PASS;
      end
   end
   // ---------------------------------------------
   // registers
   // ---------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         esr <= 8'h00;
         ese <= 8'h00;
         sre <= 8'h00;
         rqs <= 1'b0;
         mss_q <= 1'b0;
         opc_pend <= 1'b0;
         opcq_pend <= 1'b0;
         wp <= '0;
         rp <= '0;
         resp_valid <= 1'b0;
         resp_value <= 16'h0000;
         resp_is_warn <= 1'b0;
         tf_status <= `GSC_TF_PASS;
         spoll_byte <= 8'h00;
         sys_reset <= 1'b0;
      end
      else
      begin
         esr <= next_esr;
         ese <= next_ese;
         sre <= next_sre;
         rqs <= next_rqs;
         mss_q <= next_mss_q;
         opc_pend <= next_opc_pend;
         opcq_pend <= next_opcq_pend;
         wp <= next_wp;
         rp <= next_rp;
         resp_valid <= next_rv;
         resp_value <= next_rvalue;
         resp_is_warn <= next_warn;
         tf_status <= next_tf;
         spoll_byte <= stb; // raw byte, no coding
         sys_reset <= rst_cmd(cmd_valid, cmd);
      end
   end
   // ---------------------------------------------
   // installed-board list
   // ---------------------------------------------
   // one register per slot byte; slot count follows SLOTS alone
   for (genvar s = 0; s < SLOTS; s++)
   begin : g_slot
      always_ff @(posedge clk or negedge rst_b)
      begin
         if (!rst_b)
            opt_fields[8*s +: 8] <= 8'h00;
         else
            opt_fields[8*s +: 8] <= slot_ids[8*s +: 8];
      end
   end
   // ---------------------------------------------
   // error queue storage
   // ---------------------------------------------
   // queue storage has no reset; pointers define content
   always_ff @(posedge clk)
   begin
      if (log_en && !qfull)
         q_mem[wp[AW-1:0]] <= log_code;
   end
   assign srq = rqs;
endmodule
`default_nettype wire

// file: gsc_cfg.svh
// Purpose: constants for the status and common command block
// Assumes: 40 MHz clock
// Notes: error and status codes held as plain numbers
`ifndef GSC_CFG_SVH
`define GSC_CFG_SVH
`define GSC_SLOTS 18
`define GSC_ERR_NONE 10'd0
`define GSC_ERR_MNEMONIC 10'd20
`define GSC_ERR_GET_MID 10'd46
`define GSC_ERR_RANGE 10'd200
`define GSC_ERR_NOT_IDLE 10'd310
`define GSC_ERR_CAL_BUSY 10'd601
`define GSC_ERR_CAL_IDLE 10'd602
`define GSC_WARN_FIRST 10'd900
`define GSC_SRE_MAX 9'd256
`define GSC_TF_FAIL 11'sd1
`define GSC_TF_PASS 11'sd0
`define GSC_TF_WARN -11'sd1
`define GSC_TF_BREAK -11'sd1000
`define GSC_ESR_OPC 0
`define GSC_STB_ESB 5
`define GSC_STB_RQS 6
`define GSC_ERRQ_DEPTH 8
`endif

// file: gsc_pkg.sv
// Purpose: types for the status and common command block
// Assumes: nothing
// Notes: none
package gsc_pkg;
   typedef enum logic [3:0] {
      GSC_CMD_NONE, GSC_CMD_OPC, GSC_CMD_OPCQ, GSC_CMD_OPTQ, GSC_CMD_RST,
      GSC_CMD_SRE, GSC_CMD_STBQ, GSC_CMD_WAI, GSC_CMD_ESRQ, GSC_CMD_CLS,
      GSC_CMD_ERRQ, GSC_CMD_ESE
   } gsc_cmd_t;
   typedef enum logic [1:0] {GSC_TF_PASSED, GSC_TF_FAILED, GSC_TF_WARNED, GSC_TF_BROKEN} gsc_tf_t;
endpackage

// file: gsc_chk_sva.sv
// Purpose: port-level checks of gsc_core
// Assumes: bound into every gsc_core
// Notes: ports only, no body signals
`timescale 1ns/1ps
`default_nettype none
`include "gsc_cfg.svh"
module gsc_chk #(parameter int SLOTS = 18) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cmd_valid,
   input wire gsc_pkg::gsc_cmd_t cmd,
   input wire logic busy,
   input wire logic [7:0] status_cond,
   input wire logic tf_done,
   input wire gsc_pkg::gsc_tf_t tf_result,
   input wire logic spoll,
   input wire logic [7:0] spoll_byte,
   input wire logic srq,
   input wire logic resp_valid,
   input wire logic [15:0] resp_value,
   input wire logic resp_is_warn,
   input wire logic [SLOTS*8-1:0] slot_ids,
   input wire logic [SLOTS*8-1:0] opt_fields,
   input wire logic [10:0] tf_status,
   input wire logic sys_reset
);
   import gsc_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_opcq_idle;
      cmd_valid && cmd == GSC_CMD_OPCQ && !busy ##1 !busy;
   endsequence
   // a new reason in the same cycle may set the request again
   sequence s_poll_hit;
      spoll && srq && $stable(status_cond);
   endsequence
   a_query_answers: assert property (cmd_valid && cmd inside {GSC_CMD_OPTQ, GSC_CMD_STBQ,
      GSC_CMD_ESRQ, GSC_CMD_ERRQ} |=> resp_valid) else $error("query not answered");
   a_opc_answer: assert property (s_opcq_idle |-> ##[0:1] (resp_valid &&
      resp_value == 16'h0001)) else $error("completion query answer wrong");
   a_rst_pulse: assert property (cmd_valid && cmd == GSC_CMD_RST |=>
      sys_reset ##1 !sys_reset) else $error("reset pulse wrong");
   a_wait_quiet: assert property (cmd_valid && cmd == GSC_CMD_WAI |=>
      !resp_valid && !sys_reset) else $error("wait command had an effect");
   a_opt_fields: assert property (cmd_valid && cmd == GSC_CMD_OPTQ |=>
      opt_fields == $past(slot_ids) && resp_value == 16'(SLOTS)) else $error("slot list wrong");
   a_poll_raw: assert property (spoll |=> spoll_byte[`GSC_STB_RQS] == $past(srq))
      else $error("polled byte wrong");
   a_poll_clears: assert property (s_poll_hit |=> !srq) else $error("poll kept request");
   a_tf_code: assert property (tf_done |=> tf_status ==
      ($past(tf_result) == GSC_TF_FAILED ? `GSC_TF_FAIL : $past(tf_result) == GSC_TF_WARNED ?
      `GSC_TF_WARN : $past(tf_result) == GSC_TF_BROKEN ? `GSC_TF_BREAK : `GSC_TF_PASS))
      else $error("test status wrong");
   a_warn_mark: assert property (resp_valid && $past(cmd_valid && cmd == GSC_CMD_ERRQ) |->
      resp_is_warn == (resp_value >= 16'h0384)) else $error("severity wrong");
endmodule
bind gsc_core gsc_chk #(.SLOTS(SLOTS)) gsc_chk_i (.clk(clk), .rst_b(rst_b),
   .cmd_valid(cmd_valid), .cmd(cmd), .busy(busy), .status_cond(status_cond),
   .tf_done(tf_done), .tf_result(tf_result), .spoll(spoll), .spoll_byte(spoll_byte),
   .srq(srq), .resp_valid(resp_valid), .resp_value(resp_value), .resp_is_warn(resp_is_warn),
   .slot_ids(slot_ids), .opt_fields(opt_fields), .tf_status(tf_status), .sys_reset(sys_reset));
`default_nettype wire

// file: gsc_ctl_model.sv
// Purpose: bus controller that answers service requests with a poll
// Assumes: drives on the falling edge
// Notes: slow waits eight cycles before polling
`timescale 1ns/1ps
`default_nettype none
module gsc_ctl_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic slow,
   input wire logic srq,
   output logic spoll
);
   logic [3:0] cnt;
   always @(negedge clk or negedge rst_b)
   begin
      spoll <= 1'b0;
      if (!rst_b)
         cnt <= 4'h0;
      else if (srq && !spoll)
      begin
         cnt <= cnt + 4'h1;
         if (cnt == (slow ? 4'h8 : 4'h0))
         begin
            spoll <= 1'b1;
            cnt <= 4'h0;
         end
      end
   end
endmodule
`default_nettype wire

// file: testbench.sv
// Purpose: self-checking bench for gsc_core
// Assumes: inputs change at the falling edge
// Notes: error events and test results run from tables
`timescale 1ns/1ps
`default_nettype none
`include "gsc_cfg.svh"
module testbench;
   import gsc_pkg::*;
   logic clk, rst_b, cmd_valid, busy, slow, tf_done, spoll, srq, resp_valid, resp_is_warn, sys_reset;
   logic idle, cal_run;
   gsc_cmd_t cmd;
   gsc_tf_t tf_result;
   logic [8:0] cmd_arg;
   logic [5:0] evs;
   logic [7:0] status_cond, spoll_byte;
   logic [15:0] resp_value;
   logic [143:0] opt_fields, slot_ids;
   logic [10:0] tf_status;
   int failures, tests_run;
   logic [9:0] err_code [6] = '{`GSC_ERR_MNEMONIC, `GSC_ERR_GET_MID, `GSC_ERR_RANGE,
      `GSC_ERR_NOT_IDLE, `GSC_ERR_CAL_BUSY, `GSC_ERR_CAL_IDLE};
   logic [10:0] tf_code [4] = '{`GSC_TF_PASS, `GSC_TF_FAIL, `GSC_TF_WARN, `GSC_TF_BREAK};
   // cal_run flips the running level so that start and operate can also be legal
   gsc_core gsc_core_i (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_arg(cmd_arg), .busy(busy), .slot_ids(slot_ids), .bad_mnemonic(evs[0]),
      .get_mid_record(evs[1]), .param_range_err(evs[2]), .idle_cmd(evs[3]), .tester_idle(idle),
      .cal_start(evs[4]), .cal_op(evs[5]), .cal_running(evs[4] ^ cal_run),
      .status_cond(status_cond),
      .tf_done(tf_done), .tf_result(tf_result), .spoll(spoll), .spoll_byte(spoll_byte),
      .srq(srq), .resp_valid(resp_valid), .resp_value(resp_value), .resp_is_warn(resp_is_warn),
      .opt_fields(opt_fields), .tf_status(tf_status), .sys_reset(sys_reset));
   gsc_ctl_model gsc_ctl_model_i (.clk(clk), .rst_b(rst_b), .slow(slow), .srq(srq), .spoll(spoll));
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic go(input gsc_cmd_t c, input logic [8:0] a);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd = c;
      cmd_arg = a;
      @(negedge clk);
      cmd_valid = 1'b0;
   endtask
   // bounded so a missing answer cannot hang the run
   task automatic wait_lvl(ref logic s, input logic lvl);
      for (int n = 0; n < 40 && s !== lvl; n++)
      begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic ask(input gsc_cmd_t c, input logic [15:0] exp);
      go(c, 9'h000);
      wait_lvl(resp_valid, 1'b1);
      chk("resp_valid", 16'h0001, {15'h0000, resp_valid});
      chk(c.name(), exp, resp_value);
   endtask
   task automatic ev(input int i);
      @(negedge clk);
      evs[i] = 1'b1;
      @(negedge clk);
      evs = 6'h00;
   endtask
   task automatic end_sim;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      #100000;
      failures++;
      end_sim();
   end
   initial
   begin
      {rst_b, cmd_valid, busy, slow, tf_done, evs, status_cond, cmd_arg, idle, cal_run} = '0;
      {failures, tests_run} = '0;
      cmd = GSC_CMD_NONE;
      tf_result = GSC_TF_PASSED;
      slot_ids = {128'h0, 16'h1104};
      repeat (8) @(negedge clk);
      chk("resp_value in reset", 16'h0000, resp_value);
      rst_b = 1'b1;
      ask(GSC_CMD_ERRQ, 16'h0000);
      for (int i = 0; i < 6; i++)
      begin
         ev(i);
         ask(GSC_CMD_ERRQ, {6'h00, err_code[i]});
         chk("resp_is_warn", 16'h0000, {15'h0000, resp_is_warn});
      end
      for (int i = 0; i < 4; i++)
      begin
         @(negedge clk);
         tf_done = 1'b1;
         tf_result = gsc_tf_t'(i);
         @(negedge clk);
         tf_done = 1'b0;
         chk("tf_status", {5'h00, tf_code[i]}, {5'h00, tf_status});
      end
      {idle, cal_run} = 2'b11;
      ev(3);
      ev(4);
      ev(5);
      ask(GSC_CMD_ERRQ, 16'h0000);
      {idle, cal_run} = 2'b00;
      ev(0);
      ev(2);
      ask(GSC_CMD_ERRQ, 16'h0014);
      ask(GSC_CMD_ERRQ, 16'h00C8);
      go(GSC_CMD_SRE, 9'h101);
      ask(GSC_CMD_ERRQ, 16'h00C8);
      busy = 1'b1;
      go(GSC_CMD_OPCQ, 9'h000);
      @(posedge clk);
      #1;
      chk("early answer", 16'h0000, {15'h0000, resp_valid});
      @(negedge clk);
      busy = 1'b0;
      wait_lvl(resp_valid, 1'b1);
      chk("opc answer", 16'h0001, resp_value);
      ask(GSC_CMD_OPCQ, 16'h0001);
      go(GSC_CMD_OPC, 9'h000);
      ask(GSC_CMD_ESRQ, 16'h0001);
      ask(GSC_CMD_ESRQ, 16'h0000);
      ask(GSC_CMD_OPTQ, 16'h0012);
      chk("opt slot 0", 16'h0004, {8'h00, opt_fields[7:0]});
      chk("opt slot 1", 16'h0011, {8'h00, opt_fields[15:8]});
      chk("opt slot 2", 16'h0000, {8'h00, opt_fields[23:16]});
      go(GSC_CMD_ESE, 9'h001);
      go(GSC_CMD_OPC, 9'h000);
      ev(0);
      ask(GSC_CMD_STBQ, 16'h0020);
      go(GSC_CMD_CLS, 9'h000);
      ask(GSC_CMD_ESRQ, 16'h0000);
      ask(GSC_CMD_ERRQ, 16'h0000);
      status_cond = 8'h01;
      repeat (4) @(negedge clk);
      chk("masked srq", 16'h0000, {15'h0000, srq});
      go(GSC_CMD_SRE, 9'h001);
      wait_lvl(srq, 1'b1);
      chk("srq", 16'h0001, {15'h0000, srq});
      wait_lvl(srq, 1'b0);
      chk("polled byte", 16'h0041, {8'h00, spoll_byte});
      ask(GSC_CMD_STBQ, 16'h0041);
      {slow, status_cond} = {1'b1, 8'h00};
      repeat (2) @(negedge clk);
      status_cond = 8'h01;
      wait_lvl(srq, 1'b1);
      chk("srq again", 16'h0001, {15'h0000, srq});
      wait_lvl(srq, 1'b0);
      go(GSC_CMD_WAI, 9'h000);
      ev(0);
      go(GSC_CMD_RST, 9'h000);
      chk("sys_reset", 16'h0001, {15'h0000, sys_reset});
      status_cond = 8'h00;
      repeat (2) @(negedge clk);
      status_cond = 8'h01;
      repeat (4) @(negedge clk);
      chk("srq after reset", 16'h0000, {15'h0000, srq});
      ask(GSC_CMD_ERRQ, 16'h0000);
      end_sim();
   end
endmodule
`default_nettype wire
